// [inc/pom_regs.vh]
`ifndef POM_REGS_VH
`define POM_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define POM_CTRL_OFS       8'h00
`define POM_STAT_OFS       8'h04
`define POM_PATH_OFS       8'h08
`define POM_DATA_OFS       8'h0c
`define POM_RSP_OFS        8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define POM_CTRL_GO        0
`define POM_STAT_BUSY      0
`define POM_STAT_DONE      1
`define POM_STAT_ERR       2
`define POM_DATA_LEN_LO    16
`define POM_DATA_LEN_HI    17
`define POM_RSP_DATA_LO    16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define POM_PATH_RST       32'h0000_0000
`define POM_DATA_RST       18'h0_0000
`define POM_RSP_RST        24'h00_0000

// ----------------------------------------------------------------
// Object and service codes
// ----------------------------------------------------------------
`define POM_CLASS          8'h64
`define POM_SVC_READ       8'h0e
`define POM_SVC_WRITE      8'h10
`define POM_SVC_ERR        8'h94
`define POM_SVC_REPLY      8'h80
`define POM_REV_INST       8'h00
`define POM_REV_ATTR       8'h01
`define POM_REV_VALUE      16'h0001
`define POM_ATTR_MAX       8'h63
`define POM_WORD_LEN       2'h2

// ----------------------------------------------------------------
// General and additional error codes
// ----------------------------------------------------------------
`define POM_GE_SERVICE     8'h08
`define POM_GE_RDONLY      8'h0e
`define POM_GE_SHORT       8'h13
`define POM_GE_NOATTR      8'h14
`define POM_GE_LONG        8'h15
`define POM_GE_NOOBJ       8'h16
`define POM_GE_VENDOR      8'h1f
`define POM_GE_PARAM       8'h20
`define POM_AE_NONE        8'hff
`define POM_AE_NOCODE_WR   8'h02
`define POM_AE_CODE_RO     8'h03
`define POM_AE_RUN_LOCK    8'h06
`define POM_AE_X_LOCK      8'h07
`define POM_AE_RANGE       8'h08
`define POM_AE_WR_BUSY     8'h0f
`define POM_AE_NOCODE_RD   8'h21

// ----------------------------------------------------------------
// Store write result
// ----------------------------------------------------------------
`define POM_RES_OK         2'h0
`define POM_RES_RANGE      2'h1
`define POM_RES_PARAM      2'h2

`endif

// [hw/pom_handler.v]
// Overview of operation
// - Object class 0x64; instance picks parameter group, attribute picks code number.
// - Instance 00 attribute 01 reads revision word 0x0001, read-only.
// - Instance 02 holds command group, attributes 1-99, read and write words.
// - Instance 03 holds monitor group, attributes 1-99, read-only words.
// - Instances 04-09 hold six drive groups, attributes 1-99, read and write.
// - Instance 0x0A holds option-card group, attributes 1-99, read and write.
// - Instances 0x0E and 0x0F hold two more drive groups, read and write.
// - Instances 0x10-0x12 hold three monitor groups, read-only words.
// - Every parameter attribute carries one full 16-bit word, 0 to 0xFFFF.
// - Erroneous request answered with service 0x94 and error code as data.
// - Error code is general byte then additional byte; 0xFF when none.
// - Read is service 0x0E, write 0x10; any other gets general 0x08.
// - Write to write-protected attribute answered with general code 0x0E.
// - One byte to word gives 0x13; too much data gives 0x15.
// - Missing attribute gives 0x14; missing object class gives 0x16.
// - Undefined code: write gives 0x1F/0x02, read gives 0x1F/0x21.
// - Write to read-only code gives 0x1F/0x03.
// - Code locked while running gives 0x1F/0x06; locked by terminal 0x1F/0x07.
// - Write out of code's permitted range gives 0x1F/0x08.
// - Write to code still being written gives 0x1F/0x0F; master retries later.
// - Write outside attribute's valid range gives 0x20/0xFF.
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "pom_regs.vh"

module pom_handler (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Drive state pins
    input  wire        drive_run_i,
    input  wire        xterm_on_i,
    // Parameter store request
    output wire [4:0]  store_grp_o,
    output wire [6:0]  store_code_o,
    output reg         store_we_o,
    output wire [15:0] store_wdata_o,
    output wire        store_req_o,
    // Parameter store answer
    input  wire [15:0] store_rdata_i,
    input  wire        store_ack_i,
    input  wire [1:0]  store_res_i,
    // Parameter store code attributes
    input  wire        code_def_i,
    input  wire        code_ro_i,
    input  wire        code_lock_run_i,
    input  wire        code_lock_x_i,
    input  wire        code_busy_i
);

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam ST_IDLE   = 2'b00;
    localparam ST_CHECK  = 2'b01;
    localparam ST_ACCESS = 2'b10;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function [31:0] merge_bytes;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  sel;
        integer      i;
        begin
            merge_bytes = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    function group_exists;
        input [7:0] inst;
        begin
            case (inst)
                8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                8'h0a, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12: group_exists = 1'b1;
                default: group_exists = 1'b0;
            endcase
        end
    endfunction

    function group_read_only;
        input [7:0] inst;
        begin
            case (inst)
                8'h03, 8'h10, 8'h11, 8'h12: group_read_only = 1'b1;
                default: group_read_only = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [31:0] req_path;
    reg  [17:0] req_data;
    reg  [7:0]  rsp_svc;
    reg  [15:0] rsp_val;
    reg         done;
    reg         rsp_err;
    reg         run_meta;
    reg         run_sync;
    reg         xterm_meta;
    reg         xterm_sync;
    reg         chk_err;
    reg  [7:0]  chk_gen;
    reg  [7:0]  chk_add;
    reg         end_ok;
    reg         end_err;
    reg  [15:0] end_val;
    reg  [7:0]  end_gen;
    reg  [7:0]  end_add;

    wire        bus_req;
    wire        bus_wr;
    wire        busy;
    wire        go;
    wire        clr_done;
    wire [7:0]  req_svc;
    wire [7:0]  req_class;
    wire [7:0]  req_inst;
    wire [7:0]  req_attr;
    wire [1:0]  req_len;
    wire        is_write;
    wire        is_rev;
    wire [31:0] data_merged;

    assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr    = bus_req & wb_we_i;
    assign busy      = (state != ST_IDLE);
    assign go        = bus_wr & (wb_adr_i == `POM_CTRL_OFS) & wb_sel_i[0]
                       & wb_dat_i[`POM_CTRL_GO] & ~busy;
    assign clr_done  = bus_wr & (wb_adr_i == `POM_STAT_OFS) & wb_sel_i[0]
                       & wb_dat_i[`POM_STAT_DONE];
    assign req_svc   = req_path[7:0];
    assign req_class = req_path[15:8];
    assign req_inst  = req_path[23:16];
    assign req_attr  = req_path[31:24];
    assign req_len   = req_data[`POM_DATA_LEN_HI:`POM_DATA_LEN_LO];
    assign is_write  = (req_svc == `POM_SVC_WRITE);
    assign is_rev    = (req_inst == `POM_REV_INST) & (req_attr == `POM_REV_ATTR);
    assign data_merged = merge_bytes({14'h0000, req_data}, wb_dat_i, wb_sel_i);

    // ------------------------------------------------------------
    // Store side
    // ------------------------------------------------------------
    assign store_grp_o   = req_inst[4:0];
    assign store_code_o  = req_attr[6:0];
    assign store_wdata_o = req_data[15:0];
    assign store_req_o   = (state == ST_ACCESS);

    // ------------------------------------------------------------
    // Drive state synchronisers
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            run_meta   <= 1'b0;
            run_sync   <= 1'b0;
            xterm_meta <= 1'b0;
            xterm_sync <= 1'b0;
        end else begin
            run_meta   <= drive_run_i;
            run_sync   <= run_meta;
            xterm_meta <= xterm_on_i;
            xterm_sync <= xterm_meta;
        end
    end

    // ------------------------------------------------------------
    // Request check
    // ------------------------------------------------------------
    always @* begin
        chk_err = 1'b1;
        chk_add = `POM_AE_NONE;
        chk_gen = `POM_GE_SERVICE;
        if (req_svc != `POM_SVC_READ && !is_write) begin
            chk_gen = `POM_GE_SERVICE;
        end else if (req_class != `POM_CLASS) begin
            chk_gen = `POM_GE_NOOBJ;
        end else if (is_rev) begin
            chk_gen = `POM_GE_RDONLY;
            chk_err = is_write;
        end else if (!group_exists(req_inst) || req_attr == 8'h00
                     || req_attr > `POM_ATTR_MAX) begin
            chk_gen = `POM_GE_NOATTR;
        end else if (is_write && req_len < `POM_WORD_LEN) begin
            chk_gen = `POM_GE_SHORT;
        end else if (is_write && req_len > `POM_WORD_LEN) begin
            chk_gen = `POM_GE_LONG;
        end else if (is_write && group_read_only(req_inst)) begin
            chk_gen = `POM_GE_RDONLY;
        end else if (!code_def_i) begin
            chk_gen = `POM_GE_VENDOR;
            chk_add = is_write ? `POM_AE_NOCODE_WR : `POM_AE_NOCODE_RD;
        end else if (is_write && code_ro_i) begin
            chk_gen = `POM_GE_VENDOR;
            chk_add = `POM_AE_CODE_RO;
        end else if (is_write && code_lock_run_i && run_sync) begin
            chk_gen = `POM_GE_VENDOR;
            chk_add = `POM_AE_RUN_LOCK;
        end else if (is_write && code_lock_x_i && xterm_sync) begin
            chk_gen = `POM_GE_VENDOR;
            chk_add = `POM_AE_X_LOCK;
        end else if (is_write && code_busy_i) begin
            chk_gen = `POM_GE_VENDOR;
            chk_add = `POM_AE_WR_BUSY;
        end else begin
            chk_err = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        end_ok     = 1'b0;
        end_err    = 1'b0;
        end_val    = 16'h0000;
        end_gen    = chk_gen;
        end_add    = chk_add;
        case (state)
            ST_IDLE: begin
                if (go) begin
                    next_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (chk_err) begin
                    end_err    = 1'b1;
                    next_state = ST_IDLE;
                end else if (is_rev) begin
                    end_ok     = 1'b1;
                    end_val    = `POM_REV_VALUE;
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (store_ack_i) begin
                    next_state = ST_IDLE;
                    end_add    = `POM_AE_NONE;
                    if (!store_we_o || store_res_i == `POM_RES_OK) begin
                        end_ok  = 1'b1;
                        end_val = store_we_o ? 16'h0000 : store_rdata_i;
                    end else if (store_res_i == `POM_RES_RANGE) begin
                        end_err = 1'b1;
                        end_gen = `POM_GE_VENDOR;
                        end_add = `POM_AE_RANGE;
                    end else begin
                        end_err = 1'b1;
                        end_gen = `POM_GE_PARAM;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Request, response and status registers
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            state      <= ST_IDLE;
            req_path   <= `POM_PATH_RST;
            req_data   <= `POM_DATA_RST;
            {rsp_val, rsp_svc} <= `POM_RSP_RST;
            done       <= 1'b0;
            rsp_err    <= 1'b0;
            store_we_o <= 1'b0;
        end else begin
            state <= next_state;
            if (bus_wr && !busy && wb_adr_i == `POM_PATH_OFS) begin
                req_path <= merge_bytes(req_path, wb_dat_i, wb_sel_i);
            end
            if (bus_wr && !busy && wb_adr_i == `POM_DATA_OFS) begin
                req_data <= data_merged[17:0];
            end
            if (go) begin
                store_we_o <= (wb_dat_i[`POM_CTRL_GO]) & is_write;
            end
            if (end_ok) begin
                rsp_svc <= req_svc | `POM_SVC_REPLY;
                rsp_val <= end_val;
                rsp_err <= 1'b0;
            end else if (end_err) begin
                rsp_svc <= `POM_SVC_ERR;
                rsp_val <= {end_add, end_gen};
                rsp_err <= 1'b1;
            end
            if (end_ok || end_err) begin
                done <= 1'b1;
            end else if (clr_done) begin
                done <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `POM_STAT_OFS: wb_dat_o <= {29'h0000_0000, rsp_err, done, busy};
                    `POM_PATH_OFS: wb_dat_o <= req_path;
                    `POM_DATA_OFS: wb_dat_o <= {14'h0000, req_data};
                    `POM_RSP_OFS:  wb_dat_o <= {rsp_val, 8'h00, rsp_svc};
                    default:       wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// [dv/pom_chk.sv]
`timescale 1ns/10ps
module pom_chk (
    // Clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // Wishbone
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire        wb_ack_o,
    // Store side
    input wire [4:0]  store_grp_o,
    input wire [6:0]  store_code_o,
    input wire        store_we_o,
    input wire [15:0] store_wdata_o,
    input wire        store_req_o,
    input wire        store_ack_i,
    input wire        code_def_i,
    input wire        code_ro_i,
    input wire        code_busy_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire grp_ok = (store_grp_o >= 5'h02 && store_grp_o <= 5'h0a) ||
                  (store_grp_o >= 5'h0e && store_grp_o <= 5'h12);
    wire grp_ro = store_grp_o == 5'h03 || store_grp_o >= 5'h10;
    wire wr_req = store_req_o && store_we_o;
    a_grp_valid: assert property (store_req_o |-> grp_ok)
        else $error("store request to unmapped group");
    a_code_range: assert property (store_req_o |-> store_code_o >= 7'h01 &&
        store_code_o <= 7'h63) else $error("store code out of 1..99");
    a_ro_group: assert property (wr_req |-> !grp_ro)
        else $error("store write to read-only group");
    a_undef_code: assert property (store_req_o |-> code_def_i)
        else $error("store request to undefined code");
    a_ro_code: assert property (wr_req |-> !code_ro_i)
        else $error("store write to read-only code");
    a_write_busy: assert property (wr_req |-> !code_busy_i)
        else $error("store write to code still busy");
    a_req_hold: assert property (store_req_o && !store_ack_i |=> store_req_o &&
        $stable(store_wdata_o) && $stable(store_code_o))
        else $error("store request changed before answer");
    a_req_drop: assert property (store_req_o && store_ack_i |=> !store_req_o)
        else $error("store request held after answer");
    a_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse");
    c_store_wr: cover property (wr_req && store_ack_i);
    c_store_rd: cover property (store_req_o && !store_we_o && store_ack_i);
    c_bus_wr: cover property (wb_ack_o && wb_we_i);
endmodule

bind pom_handler pom_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .store_grp_o(store_grp_o), .store_code_o(store_code_o), .store_we_o(store_we_o),
    .store_wdata_o(store_wdata_o), .store_req_o(store_req_o), .store_ack_i(store_ack_i),
    .code_def_i(code_def_i), .code_ro_i(code_ro_i), .code_busy_i(code_busy_i));

// [dv/pom_store_model.sv]
`timescale 1ns/10ps
module pom_store_model (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Request
    input  wire        req_i,
    input  wire        we_i,
    input  wire [4:0]  grp_i,
    input  wire [6:0]  code_i,
    input  wire [15:0] wdata_i,
    input  wire        ok_i,
    input  wire [1:0]  dly_i,
    // Answer
    output wire [15:0] rdata_o,
    output reg         ack_o
);
    reg     [15:0] mem [0:4095];
    reg     [1:0]  cnt;
    integer        i;
    wire    [11:0] idx = {grp_i, code_i};
    initial for (i = 0; i < 4096; i = i + 1) mem[i] = 16'h0000;
    // Read word only valid with ack
    assign rdata_o = ack_o ? mem[idx] : ~mem[idx];
    always @(posedge clk_i) begin
        if (rst_i || !req_i || ack_o) begin
            ack_o <= 1'b0;
            cnt   <= 2'h0;
        end else if (cnt >= dly_i) begin
            ack_o <= 1'b1;
            if (we_i && ok_i) mem[idx] <= wdata_i;
        end else cnt <= cnt + 2'h1;
    end
endmodule

// [dv/test_pom_handler.sv]
`timescale 1ns/10ps
`include "pom_regs.vh"
module test_pom_handler;
    reg         clk_i, rst_i, cyc, stb, we, run, xt;
    reg  [7:0]  adr;
    reg  [31:0] dat, r;
    reg  [4:0]  fl;
    reg  [1:0]  res, dly;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o, store_we_o, store_req_o, store_ack_i;
    wire [4:0]  store_grp_o;
    wire [6:0]  store_code_o;
    wire [15:0] store_wdata_o, store_rdata_i;
    integer     mismatches, cmp_count, seed, j, k;
    integer     mm [0:4095];
    pom_handler dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .drive_run_i(run), .xterm_on_i(xt), .store_grp_o(store_grp_o),
        .store_code_o(store_code_o), .store_we_o(store_we_o), .store_wdata_o(store_wdata_o),
        .store_req_o(store_req_o), .store_rdata_i(store_rdata_i), .store_ack_i(store_ack_i),
        .store_res_i(res), .code_def_i(fl[4]), .code_ro_i(fl[3]), .code_lock_run_i(fl[2]),
        .code_lock_x_i(fl[1]), .code_busy_i(fl[0]));
    pom_store_model u_store (.clk_i(clk_i), .rst_i(rst_i), .req_i(store_req_o),
        .we_i(store_we_o), .grp_i(store_grp_o), .code_i(store_code_o),
        .wdata_i(store_wdata_o), .ok_i(res == 2'h0), .dly_i(dly),
        .rdata_o(store_rdata_i), .ack_o(store_ack_i));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // ----------------------------------------------------------------
    // Bus, compare and model
    // ----------------------------------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
            if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task automatic wb(input w, input [7:0] ad, input [31:0] wd, output [31:0] rd);
        integer n;
        begin
            @(posedge clk_i);
            cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; dat <= wd;
            n = 0;
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1 && n < 20) begin
                @(posedge clk_i);
                n = n + 1;
            end
            rd = wb_dat_o;
            cyc <= 1'b0; stb <= 1'b0; dat <= ~wd;
            if (n >= 20) begin mismatches = mismatches + 1; test_done; end
        end
    endtask
    function [31:0] ev(input [7:0] g, input [7:0] a);
        ev = {a, g, 8'h00, `POM_SVC_ERR};
    endfunction
    task automatic xfer(input [7:0] s, c, i, a, input [1:0] n, input [15:0] d);
        reg [31:0] e;
        reg        w, ro;
        integer    t, x;
        begin
            @(posedge clk_i);
            dly <= $random(seed);
            w = (s == `POM_SVC_WRITE);
            ro = (i == 8'h03 || i >= 8'h10);
            x = {i[4:0], a[6:0]};
            if (s != `POM_SVC_READ && !w) e = ev(8'h08, 8'hff);
            else if (c != `POM_CLASS) e = ev(8'h16, 8'hff);
            else if (i == 8'h00 && a == 8'h01)
                e = w ? ev(8'h0e, 8'hff) : {16'h0001, 8'h00, 8'h8e};
            else if (!((i >= 8'h02 && i <= 8'h0a) || (i >= 8'h0e && i <= 8'h12)) ||
                     a < 8'h01 || a > 8'h63) e = ev(8'h14, 8'hff);
            else if (w && n < 2'h2) e = ev(8'h13, 8'hff);
            else if (w && n > 2'h2) e = ev(8'h15, 8'hff);
            else if (w && ro) e = ev(8'h0e, 8'hff);
            else if (!fl[4]) e = ev(8'h1f, w ? 8'h02 : 8'h21);
            else if (w && fl[3]) e = ev(8'h1f, 8'h03);
            else if (w && fl[2] && run) e = ev(8'h1f, 8'h06);
            else if (w && fl[1] && xt) e = ev(8'h1f, 8'h07);
            else if (w && fl[0]) e = ev(8'h1f, 8'h0f);
            else if (!w) e = {mm[x][15:0], 8'h00, 8'h8e};
            else if (res == 2'h1) e = ev(8'h1f, 8'h08);
            else if (res == 2'h2) e = ev(8'h20, 8'hff);
            else begin e = {16'h0000, 8'h00, 8'h90}; mm[x] = d; end
            wb(1'b1, `POM_PATH_OFS, {a, i, c, s}, r);
            wb(1'b1, `POM_DATA_OFS, {14'h0000, n, d}, r);
            wb(1'b1, `POM_CTRL_OFS, 32'h0000_0001, r);
            t = 0;
            r = 32'h0000_0000;
            while (r[1] !== 1'b1 && t < 40) begin
                wb(1'b0, `POM_STAT_OFS, 32'h0000_0000, r);
                t = t + 1;
            end
            if (t >= 40) begin mismatches = mismatches + 1; test_done; end
            chk(r[2:0], {e[7:0] == `POM_SVC_ERR, 2'b10});
            wb(1'b0, `POM_RSP_OFS, 32'h0000_0000, r);
            chk(r, e);
            wb(1'b1, `POM_STAT_OFS, 32'h0000_0002, r);
        end
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 47913; mismatches = 0; cmp_count = 0;
        for (j = 0; j < 4096; j = j + 1) mm[j] = 0;
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0000_0000;
        run = 1'b0; xt = 1'b0; fl = 5'h10; res = 2'h0; dly = 2'h0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h20, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        wb(1'b0, `POM_STAT_OFS, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        xfer(8'h0e, 8'h64, 8'h00, 8'h01, 2'h2, 16'h0000);
        xfer(8'h10, 8'h64, 8'h00, 8'h01, 2'h2, 16'h1234);
        for (j = 0; j < 5; j = j + 1) xfer(8'h0e ^ (8'h01 << j), 8'h64, 8'h04, 8'h01, 2'h2,
            16'h0000);
        xfer(8'h94, 8'h64, 8'h04, 8'h01, 2'h2, 16'h0000);
        xfer(8'h0e, 8'h65, 8'h04, 8'h01, 2'h2, 16'h0000);
        xfer(8'h10, 8'h64, 8'h04, 8'h00, 2'h2, 16'h0000);
        xfer(8'h0e, 8'h64, 8'h04, 8'h64, 2'h2, 16'h0000);
        for (j = 0; j < 4; j = j + 1) xfer(8'h10, 8'h64, 8'h05, 8'h63, j, $random(seed));
        $display("test decode done");
        for (j = 0; j < 20; j = j + 1) begin
            k = 1 + {$random(seed)} % 99;
            xfer(8'h10, 8'h64, j, k, 2'h2, $random(seed));
            xfer(8'h0e, 8'h64, j, k, 2'h2, 16'h0000);
        end
        $display("test groups done");
        for (j = 0; j < 9; j = j + 1) begin
            @(posedge clk_i);
            fl <= (j == 0) ? 5'h00 : (j < 6) ? (5'h10 | (5'h10 >> j)) : 5'h10;
            run <= (j >= 2); xt <= (j >= 3); res <= (j > 5) ? (j - 5) % 3 : 0;
            repeat (3) @(posedge clk_i);
            xfer(8'h10, 8'h64, 8'h04, 8'h1a, 2'h2, $random(seed));
            xfer(8'h0e, 8'h64, 8'h04, 8'h1a, 2'h2, 16'h0000);
        end
        $display("test codes done");
        test_done;
    end
endmodule
